/* i2c_ctrl_flush_dma_filter.sv */
// i2c control register slice: rx flush, dma enables, filters, forced stop
//
// Functional notes
// [R1] flush resets rx path, configuration untouched
// [R2] flush crosses domains, bit self-clears when done
// [R3] software avoids rx fifo, polls flush bit
// [R4] tx dma enable, cleared on end of transfer
// [R5] rx dma enable, cleared on end of transfer
// [R6] software never sets both dma enables
// [R7] filter select: none, 1, 2, 4 clock spikes
// [R8] force stop bit generates stop condition
// [R9] writing zero never aborts a running flush
//
// The register addresses and the AHB-Lite register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module i2c_ctrl_flush_dma_filter
  import i2c_ctrl_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic [31:0] hrdata,
  output var  logic        hreadyout,
  output var  logic [1:0]  hresp,
  input  wire logic        sclPin,
  input  wire logic        sdaPin,
  output var  logic        sclOut,
  output var  logic        sclOe,
  output var  logic        sdaOut,
  output var  logic        sdaOe,
  output var  logic        sclFilt,
  output var  logic        sdaFilt,
  output var  logic        sclRise,
  output var  logic        sclFall,
  output var  logic        rxFlushReq,
  input  wire logic        rxFlushAck,
  output var  logic        dmaTxEnable,
  output var  logic        dmaRxEnable,
  input  wire logic        dmaTxEot,
  input  wire logic        dmaRxEot
);

  logic              take;
  logic              wrPend_q;
  logic [ADDR_W-1:0] wrAddr_q;
  logic              ctrlWr, statWr;
  ctrl_s             wd;
  status_s           wdStat;
  ctrl_s             ctrl_q, ctrl_d;
  status_s           stat;
  logic              stopDone_q;
  logic [31:0]       hrdata_q;
  logic              hreadyout_q;
  logic [1:0]        hresp_q;

  logic              sclS1_q, sclS2_q;
  logic              sdaS1_q, sdaS2_q;
  logic              ackS1_q, ackS2_q;
  logic              sclPrev_q, sclRise_q, sclFall_q;

  flush_st_e         flushSt_q, flushSt_d;
  logic              flushStart;
  logic              flushEnd;
  logic              rxFlushReq_q;

  logic              stopReq_q;
  logic              stopBusy, stopDone;
  pin_drive_s        drive;

  assign take   = ahb_take(hsel, htrans, hready);
  assign ctrlWr = wrPend_q && (wrAddr_q == ADDR_CONTROL);
  assign statWr = wrPend_q && (wrAddr_q == ADDR_STATUS);
  assign wd     = ctrl_s'(hwdata[15:0]);
  assign wdStat = status_s'(hwdata[4:0]);

  // ahb-lite slave: zero wait states, always okay
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= ADDR_CONTROL;
    end else begin
      wrPend_q <= take && hwrite && (hsize == HSIZE_WORD);
      if (take) begin
        wrAddr_q <= haddr[ADDR_W-1:0];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout_q <= 1'b1;
      hresp_q     <= HRESP_OKAY;
    end else begin
      hreadyout_q <= 1'b1;
      hresp_q     <= HRESP_OKAY;
    end
  end

  // control reads look at next values so a read right after a control write sees it; status reads current values
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata_q <= RD_ZERO;
    end else if (take && !hwrite) begin
      case (haddr[ADDR_W-1:0])
        ADDR_CONTROL: hrdata_q <= {CTRL_PAD, ctrl_d};
        ADDR_STATUS:  hrdata_q <= {STAT_PAD, stat};
        default:      hrdata_q <= RD_ZERO;
      endcase
    end
  end

  // pins come from the bus, two flops before anything reads them
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sclS1_q <= 1'b1;
      sclS2_q <= 1'b1;
      sdaS1_q <= 1'b1;
      sdaS2_q <= 1'b1;
      ackS1_q <= 1'b0;
      ackS2_q <= 1'b0;
    end else begin
      sclS1_q <= sclPin;
      sclS2_q <= sclS1_q;
      sdaS1_q <= sdaPin;
      sdaS2_q <= sdaS1_q;
      ackS1_q <= rxFlushAck;
      ackS2_q <= ackS1_q;
    end
  end

  i2c_spike_filter u_scl_filter (
    .mclk  (mclk),
    .rst_n (rst_n),
    .mode  (ctrl_q.filtSel),
    .din   (sclS2_q),
    .dout  (sclFilt)
  );

  i2c_spike_filter u_sda_filter (
    .mclk  (mclk),
    .rst_n (rst_n),
    .mode  (ctrl_q.filtSel),
    .din   (sdaS2_q),
    .dout  (sdaFilt)
  );

  // link clock edges seen after filtering, one pulse per edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sclPrev_q <= 1'b1;
      sclRise_q <= 1'b0;
      sclFall_q <= 1'b0;
    end else begin
      sclPrev_q <= sclFilt;
      sclRise_q <= sclFilt && !sclPrev_q;
      sclFall_q <= !sclFilt && sclPrev_q;
    end
  end

  // four-phase handshake with the serial side; the bit tracks the state
  assign flushStart = ctrlWr && wd.rxFlush && (flushSt_q == FL_IDLE);
  assign flushEnd   = (flushSt_q == FL_WAIT) && !ackS2_q;

  always_comb begin
    flushSt_d = flushSt_q;
    case (flushSt_q)
      FL_IDLE: if (flushStart) flushSt_d = FL_REQ; // [R1]
      FL_REQ:  if (ackS2_q) flushSt_d = FL_WAIT;
      FL_WAIT: if (!ackS2_q) flushSt_d = FL_IDLE; // [R2]
      default: flushSt_d = FL_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flushSt_q    <= FL_IDLE;
      rxFlushReq_q <= 1'b0;
    end else begin
      flushSt_q    <= flushSt_d;
      rxFlushReq_q <= (flushSt_d == FL_REQ); // [R1]
    end
  end

  // a software write wins over an end of transfer in the same cycle
  always_comb begin
    ctrl_d = ctrl_q;
    if (ctrlWr) begin
      ctrl_d.cfgLow    = wd.cfgLow;
      ctrl_d.dmaTx     = wd.dmaTx; // [R4]
      ctrl_d.dmaRx     = wd.dmaRx; // [R5]
      ctrl_d.filtSel   = wd.filtSel; // [R7]
      ctrl_d.forceStop = wd.forceStop; // [R8]
    end else begin
      if (dmaTxEot) ctrl_d.dmaTx = 1'b0; // [R4]
      if (dmaRxEot) ctrl_d.dmaRx = 1'b0; // [R5]
    end
    ctrl_d.rsvd    = CTRL_RST.rsvd;
    ctrl_d.rxFlush = (flushSt_d != FL_IDLE); // [R9]
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RST;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // only a 0 to 1 write of the force bit launches a new stop
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stopReq_q <= 1'b0;
    end else begin
      stopReq_q <= ctrlWr && wd.forceStop && !ctrl_q.forceStop; // [R8]
    end
  end

  i2c_stop_gen u_stop_gen (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .start    (stopReq_q),
    .enable   (ctrl_q.forceStop),
    .sclLevel (sclFilt),
    .drive    (drive),
    .busy     (stopBusy),
    .done     (stopDone)
  );

  // stop completion is sticky; a new completion beats a clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stopDone_q <= 1'b0;
    end else if (stopDone) begin
      stopDone_q <= 1'b1;
    end else if (statWr && wdStat.stopDone) begin
      stopDone_q <= 1'b0;
    end
  end

  always_comb begin
    stat.stopDone  = stopDone_q;
    stat.stopBusy  = stopBusy;
    stat.flushBusy = ctrl_q.rxFlush;
    stat.sdaLevel  = sdaFilt;
    stat.sclLevel  = sclFilt;
  end

  assign hrdata      = hrdata_q;
  assign hreadyout   = hreadyout_q;
  assign hresp       = hresp_q;
  assign sclOut      = drive.sclOut;
  assign sclOe       = drive.sclOe;
  assign sdaOut      = drive.sdaOut;
  assign sdaOe       = drive.sdaOe;
  assign sclRise     = sclRise_q;
  assign sclFall     = sclFall_q;
  assign rxFlushReq  = rxFlushReq_q;
  assign dmaTxEnable = ctrl_q.dmaTx; // [R4]
  assign dmaRxEnable = ctrl_q.dmaRx; // [R5]

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_flush_go;
    ctrlWr && wd.rxFlush && (flushSt_q == FL_IDLE);
  endsequence

  sequence s_req_up;
    rxFlushReq_q && ctrl_q.rxFlush;
  endsequence

  sequence s_stop_go;
    ctrlWr && wd.forceStop && !ctrl_q.forceStop;
  endsequence

  a_flush_start: assert property (s_flush_go |=> s_req_up) // [R1]
    else $error("flush request not raised after flush write");

  a_flush_cfg: assert property ( // [R1]
    (ctrl_q.rxFlush && !ctrlWr) |=> ($stable(ctrl_q.cfgLow) && $stable(ctrl_q.filtSel)))
    else $error("configuration changed during flush");

  a_flush_done: assert property (flushEnd |=> (!ctrl_q.rxFlush && !rxFlushReq_q)) // [R2]
    else $error("flush bit not cleared on completion");

  a_flush_hold: assert property ((ctrl_q.rxFlush && !flushEnd) |=> ctrl_q.rxFlush) // [R9]
    else $error("flush bit dropped before completion");

  a_flush_ack: assert property ((flushSt_q == FL_REQ && ackS2_q) |=> !rxFlushReq_q) // [R2]
    else $error("flush request held after acknowledge");

  a_dmatx_set: assert property ((ctrlWr && wd.dmaTx) |=> dmaTxEnable) // [R4]
    else $error("tx dma enable not set by write");

  a_dmatx_clear: assert property ((dmaTxEnable && dmaTxEot && !ctrlWr) |=> !dmaTxEnable) // [R4]
    else $error("tx dma enable kept after end of transfer");

  a_dmarx_clear: assert property ((dmaRxEnable && dmaRxEot && !ctrlWr) |=> !dmaRxEnable) // [R5]
    else $error("rx dma enable kept after end of transfer");

  a_stop_issue: assert property (s_stop_go |-> ##[1:3] (sdaOe && sclOe)) // [R8]
    else $error("forced stop did not start driving the bus");

  a_stop_off: assert property (!ctrl_q.forceStop |=> (!sdaOe && !sclOe)) // [R8]
    else $error("bus driven while forced stop disabled");

endmodule
`default_nettype wire

/* i2c_ctrl_pkg.sv */
// shared constants, types and helpers for the i2c control slice
package i2c_ctrl_pkg;

  localparam int unsigned ADDR_W       = 12;
  localparam logic [11:0] ADDR_CONTROL = 12'h000;
  localparam logic [11:0] ADDR_STATUS  = 12'h060;
  localparam logic [2:0]  HSIZE_WORD   = 3'h2;
  localparam logic [1:0]  HRESP_OKAY   = 2'h0;
  localparam logic [15:0] CTRL_PAD     = 16'h0000;
  localparam logic [26:0] STAT_PAD     = 27'h000_0000;
  localparam logic [31:0] RD_ZERO      = 32'h0000_0000;

  localparam int unsigned CLK_FREQ_MHZ  = 40;
  localparam int unsigned NS_PER_US     = 1000;
  localparam int unsigned STOP_HOLD_NS  = 5000;
  localparam int unsigned STOP_HOLD_CYC =
    (STOP_HOLD_NS * CLK_FREQ_MHZ + NS_PER_US - 1) / NS_PER_US;
  localparam logic [7:0]  STOP_HOLD_LAST = 8'(STOP_HOLD_CYC - 1);
  localparam logic [7:0]  CNT8_ONE       = 8'h01;
  localparam logic [7:0]  CNT8_ZERO      = 8'h00;

  typedef enum logic [1:0] {
    FILT_NONE = 2'h0,
    FILT_1CK  = 2'h1,
    FILT_2CK  = 2'h2,
    FILT_4CK  = 2'h3
  } filt_sel_e;

  localparam logic [2:0] SPIKE_NONE = 3'h0;
  localparam logic [2:0] SPIKE_1CK  = 3'h1;
  localparam logic [2:0] SPIKE_2CK  = 3'h2;
  localparam logic [2:0] SPIKE_4CK  = 3'h4;
  localparam logic [2:0] CNT3_ONE   = 3'h1;

  typedef struct packed {
    logic       forceStop;
    filt_sel_e  filtSel;
    logic [1:0] rsvd;
    logic       dmaRx;
    logic       dmaTx;
    logic       rxFlush;
    logic [7:0] cfgLow;
  } ctrl_s;
  localparam ctrl_s CTRL_RST = 16'h0000;

  typedef struct packed {
    logic stopDone;
    logic stopBusy;
    logic flushBusy;
    logic sdaLevel;
    logic sclLevel;
  } status_s;

  typedef struct packed {
    logic sclOut;
    logic sclOe;
    logic sdaOut;
    logic sdaOe;
  } pin_drive_s;
  localparam pin_drive_s PIN_RELEASE = 4'h0;
  localparam pin_drive_s PIN_BOTH_LOW = 4'h5;
  localparam pin_drive_s PIN_SDA_LOW  = 4'h1;

  typedef enum logic [1:0] {
    FL_IDLE = 2'h0,
    FL_REQ  = 2'h1,
    FL_WAIT = 2'h3
  } flush_st_e;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'h0,
    ST_LOW    = 2'h1,
    ST_SCLREL = 2'h3,
    ST_SDAREL = 2'h2
  } stop_st_e;

  function automatic logic [2:0] spike_limit(input filt_sel_e m);
    case (m)
      FILT_1CK: return SPIKE_1CK;
      FILT_2CK: return SPIKE_2CK;
      FILT_4CK: return SPIKE_4CK;
      default:  return SPIKE_NONE;
    endcase
  endfunction

  function automatic logic ahb_take(input logic sel, input logic [1:0] tr,
                                    input logic rdy);
    return sel & tr[1] & rdy;
  endfunction

endpackage

/* i2c_spike_filter.sv */
// digital spike filter for one synchronised bus line
`timescale 1ns/1ps
`default_nettype none
module i2c_spike_filter
  import i2c_ctrl_pkg::*;
(
  input  wire logic      mclk,
  input  wire logic      rst_n,
  input  wire filt_sel_e mode,
  input  wire logic      din,
  output var  logic      dout
);

  logic       dout_q;
  logic [2:0] run_q;
  logic       diff;

  assign diff = din ^ dout_q;
  assign dout = dout_q;

  // the line only follows after limit+1 differing cycles in a row
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dout_q <= 1'b1;
      run_q  <= SPIKE_NONE;
    end else if (mode == FILT_NONE) begin
      dout_q <= din;
      run_q  <= SPIKE_NONE;
    end else if (!diff) begin
      run_q <= SPIKE_NONE;
    end else if (run_q == spike_limit(mode)) begin // [R7]
      dout_q <= din;
      run_q  <= SPIKE_NONE;
    end else begin
      run_q <= run_q + CNT3_ONE;
    end
  end

  a_spike_one: assert property (@(posedge mclk) disable iff (!rst_n) // [R7]
    ($changed(dout_q) && $past(mode) == FILT_1CK && $past(mode, 2) == FILT_1CK)
    |-> ($past(diff) && $past(diff, 2)))
    else $error("1-clock spike passed the filter");

  a_spike_none: assert property (@(posedge mclk) disable iff (!rst_n) // [R7]
    (mode == FILT_NONE) |=> (dout_q == $past(din)))
    else $error("unfiltered line did not follow input");

endmodule
`default_nettype wire

/* i2c_stop_gen.sv */
// forced stop condition sequencer driving the open-drain lines
`timescale 1ns/1ps
`default_nettype none
module i2c_stop_gen
  import i2c_ctrl_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       start,
  input  wire logic       enable,
  input  wire logic       sclLevel,
  output var  pin_drive_s drive,
  output var  logic       busy,
  output var  logic       done
);

  stop_st_e   st_q, st_d;
  logic [7:0] cnt_q;
  logic       cntEnd;
  pin_drive_s drive_q;
  logic       busy_q, done_q;

  assign cntEnd = (cnt_q == STOP_HOLD_LAST);
  assign drive  = drive_q;
  assign busy   = busy_q;
  assign done   = done_q;

  // clearing the enable drops the sequence and frees both lines
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE:   if (start) st_d = ST_LOW;
      ST_LOW:    if (cntEnd) st_d = ST_SCLREL;
      ST_SCLREL: if (cntEnd) st_d = ST_SDAREL;
      ST_SDAREL: if (cntEnd) st_d = ST_IDLE;
      default:   st_d = ST_IDLE;
    endcase
    if (!enable) st_d = ST_IDLE;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // hold time restarts while a target stretches scl low
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= CNT8_ZERO;
    end else if (st_d != st_q || (st_q == ST_SCLREL && !sclLevel)) begin
      cnt_q <= CNT8_ZERO;
    end else if (st_q != ST_IDLE) begin
      cnt_q <= cnt_q + CNT8_ONE;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      drive_q <= PIN_RELEASE;
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
    end else begin
      case (st_d)
        ST_LOW:    drive_q <= PIN_BOTH_LOW;
        ST_SCLREL: drive_q <= PIN_SDA_LOW; // [R8]
        default:   drive_q <= PIN_RELEASE;
      endcase
      busy_q <= (st_d != ST_IDLE);
      done_q <= (st_q == ST_SDAREL) && (st_d == ST_IDLE) && enable;
    end
  end

  a_stop_order: assert property (@(posedge mclk) disable iff (!rst_n) // [R8]
    ($fell(drive_q.sdaOe) && $past(enable)) |-> (!drive_q.sclOe && !$past(drive_q.sclOe)))
    else $error("sda released while scl still held low");

endmodule
`default_nettype wire

/* i2c_bus_partner.sv */
// far side model: pulled-up bus lines, a clock-stretching peer, serial-side flush ack
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_partner (
  input  wire logic       mclk,
  input  wire logic       sclOe,
  input  wire logic       sdaOe,
  input  wire logic       pullLow,
  input  wire logic       rxFlushReq,
  input  wire logic [7:0] delay,
  output var  logic       sclPin,
  output var  logic       sdaPin,
  output var  logic       rxFlushAck
);
  logic [7:0] stretchQ;
  logic [7:0] ackCnt;

  initial begin
    stretchQ   = 8'h00;
    ackCnt     = 8'h00;
    rxFlushAck = 1'b0;
  end

  // released lines float to the pull-up level, never to the last driven value
  assign sclPin = ~(sclOe | pullLow | (stretchQ != 8'h00));
  assign sdaPin = ~(sdaOe | pullLow);

  // a slow peer keeps scl low for a while after the stop sequencer lets go;
  // loaded while scl is held so the line never bounces high in between
  always @(posedge mclk) begin
    if (sclOe)
      stretchQ <= delay;
    else if (stretchQ != 8'h00)
      stretchQ <= stretchQ - 8'h01;
  end

  // four-phase ack: each edge of the request is answered after delay+1 cycles
  always @(posedge mclk) begin
    if (rxFlushReq == rxFlushAck)
      ackCnt <= 8'h00;
    else if (ackCnt == delay) begin
      rxFlushAck <= rxFlushReq;
      ackCnt     <= 8'h00;
    end
    else
      ackCnt <= ackCnt + 8'h01;
  end
endmodule
`default_nettype wire

/* tb.sv */
// self-checking bench for the i2c control slice
`timescale 1ns/1ps
`default_nettype none
module tb;
  import i2c_ctrl_pkg::*;
  logic        mclk, rst_n, hsel, hwrite, sclPin, sdaPin, sclOut, sclOe, sdaOut, sdaOe;
  logic        sclFilt, sdaFilt, rxFlushReq, rxFlushAck, dmaTxEnable, dmaRxEnable;
  logic        dmaTxEot, dmaRxEot, hreadyout, pullLow, rdPend, sclRise, sclFall;
  logic [1:0]  htrans, hresp;
  logic [2:0]  hsize;
  logic [7:0]  delay;
  logic [31:0] haddr, hwdata, hrdata, lastRd, v;
  logic [63:0] expQ[$];
  logic [1:0]  seen;
  int          num_errors, comparisons, cycles, seed, n, edgeCnt;
  int          lim[4] = '{0, 1, 2, 4};

  i2c_ctrl_flush_dma_filter i2c_ctrl_flush_dma_filter_i (
    .mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sclPin(sclPin),
    .sdaPin(sdaPin), .sclOut(sclOut), .sclOe(sclOe), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .sclFilt(sclFilt), .sdaFilt(sdaFilt), .sclRise(sclRise), .sclFall(sclFall),
    .rxFlushReq(rxFlushReq), .rxFlushAck(rxFlushAck), .dmaTxEnable(dmaTxEnable),
    .dmaRxEnable(dmaRxEnable), .dmaTxEot(dmaTxEot), .dmaRxEot(dmaRxEot));

  i2c_bus_partner i2c_bus_partner_i (
    .mclk(mclk), .sclOe(sclOe), .sdaOe(sdaOe), .pullLow(pullLow),
    .rxFlushReq(rxFlushReq), .delay(delay), .sclPin(sclPin), .sdaPin(sdaPin),
    .rxFlushAck(rxFlushAck));

  always #12.5 mclk = ~mclk;

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic end_of_test;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // single word transfer; a read notes {expected, mask} for the watcher
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      input logic [31:0] m);
    if (!wr)
      expQ.push_back({d, m});
    @(posedge mclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize  <= HSIZE_WORD;
    haddr  <= {20'h0_0000, a};
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
  endtask

  // bounded wait for the pull-down enables to reach a level pair
  task automatic waitOe(input logic [1:0] lv, output int k);
    k = 0;
    #1;
    while ({sclOe, sdaOe} !== lv && k < 1000) begin
      @(posedge mclk);
      #1;
      k++;
    end
  endtask

  // both lines pulled low for w cycles while the filtered levels are watched
  task automatic glitch(input int w, output logic [1:0] s);
    s = 2'b11;
    @(posedge mclk);
    pullLow <= 1'b1;
    for (int j = 0; j < w + 12; j++) begin
      @(posedge mclk);
      if (j == w - 1)
        pullLow <= 1'b0;
      #1;
      s &= {sclFilt, sdaFilt};
    end
  endtask

  always @(posedge mclk) begin
    logic [63:0] e;
    if (rdPend && hreadyout === 1'b1 && expQ.size() > 0) begin
      e = expQ.pop_front();
      lastRd = hrdata;
      check("hrdata", e[63:32] & e[31:0], hrdata & e[31:0]);
      check("hresp", HRESP_OKAY, hresp);
    end
    if (hreadyout === 1'b1)
      rdPend <= hsel & htrans[1] & ~hwrite;
  end

  // every filtered scl edge pulse is counted
  always @(posedge mclk) begin
    if (sclRise === 1'b1 || sclFall === 1'b1)
      edgeCnt++;
  end

  // hang guard, far above the thousand or so cycles the sequence needs
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      end_of_test();
    end
  end

  initial begin
    {mclk, rst_n, hsel, hwrite, dmaTxEot, dmaRxEot, pullLow, rdPend} = 8'h00;
    {htrans, hsize, haddr, hwdata} = 69'h0;
    num_errors  = 0;
    comparisons = 0;
    cycles      = 0;
    edgeCnt     = 0;
    seed  = 41484;
    delay = 8'h02;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    xfer(0, ADDR_CONTROL, 32'h0000_0000, 32'hFFFF_FFFF);
    xfer(0, 12'h100, 32'h0000_0000, 32'hFFFF_FFFF);
    for (int m = 0; m < 4; m++) begin
      v = {16'h0000, 1'b0, 2'(m), 5'h00, 8'($random(seed))};
      xfer(1, ADDR_CONTROL, v, 32'h0000_0000);
      xfer(0, ADDR_CONTROL, v, 32'hFFFF_FFFF);
      for (int k = 0; k < 2; k++) begin
        if (lim[m] + 2 * k == 0)
          continue;
        n = edgeCnt;
        glitch(lim[m] + 2 * k, seen);
        check("filtGlitch", k ? 32'h0 : 32'h3, {30'h0, seen});
        check("sclEdges", k ? 32'h2 : 32'h0, edgeCnt - n);
      end
    end
    for (int i = 0; i < 2; i++) begin
      // one dma direction at a time, never both
      v = 32'h0000_0200 << i;
      xfer(1, ADDR_CONTROL, v, 32'h0000_0000);
      xfer(0, ADDR_CONTROL, v, 32'hFFFF_FFFF);
      check("dmaEnable", v[10:9], {dmaRxEnable, dmaTxEnable});
      {dmaRxEot, dmaTxEot} <= 2'b01 << i;
      @(posedge mclk);
      {dmaRxEot, dmaTxEot} <= 2'b00;
      xfer(0, ADDR_CONTROL, 32'h0000_0000, 32'hFFFF_FFFF);
    end
    delay <= 8'h28;
    v = {24'h00_0000, 8'($random(seed))};
    xfer(1, ADDR_CONTROL, v | 32'h0000_0100, 32'h0000_0000);
    xfer(0, ADDR_CONTROL, v | 32'h0000_0100, 32'hFFFF_FFFF);
    check("flushReq", 32'h1, rxFlushReq);
    xfer(1, ADDR_CONTROL, v, 32'h0000_0000);
    xfer(0, ADDR_CONTROL, v | 32'h0000_0100, 32'hFFFF_FFFF);
    // rx fifo left alone; only the flush bit is polled
    n = 0;
    do begin
      xfer(0, ADDR_CONTROL, v, 32'hFFFF_FEFF);
      #1;
      n++;
    end while (lastRd[8] !== 1'b0 && n < 60);
    check("flushClear", 32'h0, {31'h0, lastRd[8]});
    check("flushReqDone", 32'h0, rxFlushReq);
    delay <= 8'h1E;
    xfer(1, ADDR_CONTROL, 32'h0000_8000, 32'h0000_0000);
    waitOe(2'b11, n);
    check("stopStart", 32'h1, n <= 4);
    check("pinLevel", 32'h0, {sclOut, sdaOut});
    waitOe(2'b01, n);
    check("sclHold", 32'h1, n >= STOP_HOLD_CYC - 1);
    waitOe(2'b00, n);
    check("sdaHold", 32'h1, n >= STOP_HOLD_CYC + 30);
    repeat (STOP_HOLD_CYC + 10) @(posedge mclk);
    xfer(0, ADDR_STATUS, 32'h0000_0013, 32'h0000_001F);
    xfer(1, ADDR_STATUS, 32'h0000_0010, 32'h0000_0000);
    xfer(0, ADDR_STATUS, 32'h0000_0003, 32'h0000_001F);
    xfer(1, ADDR_CONTROL, 32'h0000_0000, 32'h0000_0000);
    xfer(1, ADDR_CONTROL, 32'h0000_8000, 32'h0000_0000);
    repeat (20) @(posedge mclk);
    xfer(1, ADDR_CONTROL, 32'h0000_0000, 32'h0000_0000);
    waitOe(2'b00, n);
    check("stopAbort", 32'h1, n <= 3);
    repeat (5) @(posedge mclk);
    end_of_test();
  end
endmodule
`default_nettype wire
